// ### rtl/lgac_gate_control.sv
// Purpose: address line 20 gate control with host latch and fast port
// Assumes: rstn is the system reset and is asserted at main power-on
// Notes: gate output is registered, two cycles after a gate data byte, one after any other cause
// Operation
// - fast port bit 1 drives alternate gate
// - gate is alternate gate OR controller source
// - assist enable selects firmware bit as source
// - firmware bit 0 at 100h sets gate
// - gate control reads bits 7..1 zero
// - separate storage; readback follows assist enable
// - data after gate command loads host latch
// - gate sequence hidden from firmware flags
// - power-on reset drives gate high
// - writes to 108h set, 10Ch clear latch
// - only data bit 1 used; FF keeps
// - repeated gate commands restart data wait
// - other command after gate command flags input
// - extra data byte flags input, goes idle
// - commands FF, FE, D1 suppress write strobe
// - disabled fast port ignores writes, floats reads
// - without assist, gate follows host latch
// - command flag separates commands from data
`timescale 1ns/1ps
module lgac_gate_control (
    input wire logic core_clk,
    input wire logic rstn,
    input lgac_pkg::lgac_ec_req_type ecReq,
    output logic [7:0] ecRdata,
    input lgac_pkg::lgac_io_req_type ioReq,
    output logic [7:0] ioRdata,
    output logic ioRdataOeN,
    input lgac_pkg::lgac_kbd_wr_type kbdWr,
    output logic internalWriteStrobeN,
    output logic kbdCmdOut,
    output logic [7:0] kbdDataOut,
    output logic outputFullBlock,
    input wire logic firmwareAssistEnable,
    input wire logic fastPortEnable,
    output logic fastPortReset,
    output logic addressLine20Gate
);

    lgac_pkg::lgac_main_state_type q, d;
    logic seqLoad;
    logic seqValue;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic ecHit(input lgac_pkg::lgac_ec_req_type r,
                                   input logic [11:0] off);
        ecHit = (r.addr == off);
    endfunction

    function automatic logic kbcSource(input logic assist, input logic fw,
                                       input logic latch);
        kbcSource = assist ? fw : latch;
    endfunction

    // ----------------------------------------------------------------
    // host sequence decoder
    // ----------------------------------------------------------------
    lgac_seq_fsm u_seq (
        .core_clk(core_clk),
        .rstn(rstn),
        .kbd(kbdWr),
        .internalWriteStrobeN(internalWriteStrobeN),
        .kbdCmdOut(kbdCmdOut),
        .kbdDataOut(kbdDataOut),
        .latchLoad(seqLoad),
        .latchValue(seqValue),
        .outputFullBlock(outputFullBlock)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic fastHit;
        fastHit = 1'h0;
        d = q;
        d.ioOeN = 1'h1;

        // firmware gate bit
        if (ecReq.write && ecHit(ecReq, lgac_pkg::GATE_CTRL_OFF))
        begin
            d.fwGate = ecReq.wdata[lgac_pkg::GATE_CTRL_BIT];
        end

        // host latch: sequence load, then firmware strobes win
        if (seqLoad)
        begin
            d.hostLatch = seqValue;
        end
        if (ecReq.write && ecHit(ecReq, lgac_pkg::LATCH_SET_OFF))
        begin
            d.hostLatch = 1'h1;
        end
        else if (ecReq.write && ecHit(ecReq, lgac_pkg::LATCH_CLR_OFF))
        begin
            d.hostLatch = 1'h0;
        end

        // fast port register
        fastHit = (ioReq.addr == lgac_pkg::FAST_PORT_IO_ADDR) && fastPortEnable;
        if (ioReq.write && fastHit)
        begin
            d.fastPort = ioReq.wdata[1:0];
        end
        else if (ecReq.write && ecHit(ecReq, lgac_pkg::FAST_PORT_EC_OFF))
        begin
            d.fastPort = ecReq.wdata[1:0];
        end

        // gate output
        d.gate = kbcSource(firmwareAssistEnable, d.fwGate, d.hostLatch)
            | d.fastPort[lgac_pkg::FAST_GATE_BIT];

        // firmware reads
        if (ecReq.read)
        begin
            if (ecHit(ecReq, lgac_pkg::GATE_CTRL_OFF))
            begin
                d.ecRdata = {7'h00, kbcSource(firmwareAssistEnable, q.fwGate,
                    q.hostLatch)};
            end
            else if (ecHit(ecReq, lgac_pkg::FAST_PORT_EC_OFF))
            begin
                d.ecRdata = {6'h00, q.fastPort};
            end
            else
            begin
                d.ecRdata = 8'h00;
            end
        end

        // host reads
        if (ioReq.read && fastHit)
        begin
            d.ioRdata = {6'h00, q.fastPort};
            d.ioOeN = 1'h0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            q <= lgac_pkg::MAIN_RST_STATE;
        else
            q <= d;
    end

    assign ecRdata = q.ecRdata;
    assign ioRdata = q.ioRdata;
    assign ioRdataOeN = q.ioOeN;
    assign fastPortReset = q.fastPort[lgac_pkg::FAST_RESET_BIT];
    assign addressLine20Gate = q.gate;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // ----------------------------------------------------------------
    // fast port checks
    // ----------------------------------------------------------------
    fast_write_a: assert property (
        fastPortEnable && ioReq.write && ioReq.addr == 16'h0092
        |=> q.fastPort[1] == $past(ioReq.wdata[1]))
        else $error("fast port write did not reach alternate gate");

    fast_reset_a: assert property (
        fastPortEnable && ioReq.write && ioReq.addr == 16'h0092
        |=> fastPortReset == $past(ioReq.wdata[0]))
        else $error("fast port write did not reach reset bit");

    ec_fast_a: assert property (
        ecReq.write && ecReq.addr == 12'h000
        && !(fastPortEnable && ioReq.write && ioReq.addr == 16'h0092)
        |=> q.fastPort == $past(ecReq.wdata[1:0]))
        else $error("firmware write to fast port lost");

    ec_read_fast_a: assert property (
        ecReq.read && ecReq.addr == 12'h000 |=> ecRdata == {6'h00, $past(q.fastPort)})
        else $error("firmware read of fast port wrong");

    port_off_a: assert property (
        !fastPortEnable && ioReq.write && !(ecReq.write && ecReq.addr == 12'h000)
        |=> $stable(q.fastPort))
        else $error("disabled fast port accepted a write");

    float_a: assert property (
        !fastPortEnable |=> ioRdataOeN)
        else $error("disabled fast port drove the data bus");

    io_read_a: assert property (
        fastPortEnable && ioReq.read && ioReq.addr == 16'h0092
        |=> !ioRdataOeN && ioRdata == {6'h00, $past(q.fastPort)})
        else $error("enabled fast port read not answered");

    oe_idle_a: assert property (
        !(fastPortEnable && ioReq.read && ioReq.addr == 16'h0092) |=> ioRdataOeN)
        else $error("data bus driven without a fast port read");

    io_hold_a: assert property (
        !(fastPortEnable && ioReq.read && ioReq.addr == 16'h0092)
        |=> $stable(ioRdata))
        else $error("host read data changed without a read");

    // ----------------------------------------------------------------
    // gate output checks
    // ----------------------------------------------------------------
    gate_or_a: assert property (
        1'h1 |=> addressLine20Gate == (($past(firmwareAssistEnable) ? q.fwGate : q.hostLatch)
        | q.fastPort[1]))
        else $error("gate output is not the OR of its sources");

    alt_high_a: assert property (
        q.fastPort[1] |-> addressLine20Gate)
        else $error("gate low while alternate gate high");

    assist_sel_a: assert property (
        firmwareAssistEnable && !d.fastPort[1] |=> addressLine20Gate == q.fwGate)
        else $error("assist enable did not select firmware bit");

    latch_path_a: assert property (
        !firmwareAssistEnable && !d.fastPort[1] |=> addressLine20Gate == q.hostLatch)
        else $error("gate does not follow host latch");

    gate_hold_a: assert property (
        $past(rstn) && !seqLoad && !ecReq.write && !ioReq.write
        && $stable(firmwareAssistEnable) |=> $stable(addressLine20Gate))
        else $error("gate changed without a cause");

    power_on_a: assert property (@(posedge core_clk) disable iff (1'h0)
        !rstn |=> addressLine20Gate && q.hostLatch && !q.fwGate)
        else $error("gate not high after reset");

    // ----------------------------------------------------------------
    // firmware register checks
    // ----------------------------------------------------------------
    fw_write_a: assert property (
        ecReq.write && ecReq.addr == 12'h100 |=> q.fwGate == $past(ecReq.wdata[0]))
        else $error("firmware gate bit not written");

    fw_hold_a: assert property (
        !(ecReq.write && ecReq.addr == 12'h100) |=> $stable(q.fwGate))
        else $error("firmware gate bit changed without a write");

    high_zero_a: assert property (
        $past(ecReq.read) && $past(ecReq.addr) == 12'h100 |-> ecRdata[7:1] == 7'h00)
        else $error("gate control upper bits not zero");

    read_sel_a: assert property (
        ecReq.read && ecReq.addr == 12'h100
        |=> ecRdata[0] == $past(firmwareAssistEnable ? q.fwGate : q.hostLatch))
        else $error("gate control readback wrong source");

    rdata_hold_a: assert property (
        !ecReq.read |=> $stable(ecRdata))
        else $error("firmware read data changed without a read");

    unmapped_a: assert property (
        ecReq.read && !(ecReq.addr inside {12'h000, 12'h100}) |=> ecRdata == 8'h00)
        else $error("unmapped or strobe offset read not zero");

    set_strobe_a: assert property (
        ecReq.write && ecReq.addr == 12'h108 |=> q.hostLatch)
        else $error("set strobe did not set host latch");

    clr_strobe_a: assert property (
        ecReq.write && ecReq.addr == 12'h10c |=> !q.hostLatch)
        else $error("clear strobe did not clear host latch");

    seq_load_a: assert property (
        seqLoad && !(ecReq.write && ecReq.addr inside {12'h108, 12'h10c})
        |=> q.hostLatch == $past(seqValue))
        else $error("gate sequence did not load host latch");

    latch_hold_a: assert property (
        !seqLoad && !(ecReq.write && ecReq.addr inside {12'h108, 12'h10c})
        |=> $stable(q.hostLatch))
        else $error("host latch changed without a cause");

    // ----------------------------------------------------------------
    // scenario covers
    // ----------------------------------------------------------------
    fast_gate_c: cover property (
        fastPortEnable && ioReq.write && ioReq.addr == 16'h0092 ##1 addressLine20Gate);

    strobe_clr_c: cover property (
        ecReq.write && ecReq.addr == 12'h10c ##1 !addressLine20Gate);

    assist_c: cover property (
        firmwareAssistEnable && ecReq.read && ecReq.addr == 12'h100);

endmodule

// ### rtl/lgac_pkg.sv
// Purpose: shared constants and types of the legacy gate control block
// Assumes: 8-bit firmware registers, 16-bit host I/O address
// Notes: offsets are byte offsets on the firmware peripheral bus
package lgac_pkg;

    // ----------------------------------------------------------------
    // address map
    // ----------------------------------------------------------------
    localparam int EC_ADDR_W = 12;
    localparam int IO_ADDR_W = 16;
    localparam logic [11:0] FAST_PORT_EC_OFF = 12'h000;
    localparam logic [11:0] GATE_CTRL_OFF = 12'h100;
    localparam logic [11:0] LATCH_SET_OFF = 12'h108;
    localparam logic [11:0] LATCH_CLR_OFF = 12'h10c;
    localparam logic [15:0] FAST_PORT_IO_ADDR = 16'h0092;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int GATE_CTRL_BIT = 0;
    localparam int FAST_RESET_BIT = 0;
    localparam int FAST_GATE_BIT = 1;
    localparam int DATA_GATE_BIT = 1;

    // ----------------------------------------------------------------
    // host command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_GATE = 8'hd1;
    localparam logic [7:0] CMD_NOP = 8'hff;
    localparam logic [7:0] CMD_PULSE = 8'hfe;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic GATE_CTRL_RST = 1'h0;
    localparam logic HOST_LATCH_RST = 1'h1;
    localparam logic [1:0] FAST_PORT_RST = 2'h0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_CMD, SEQ_DATA} lgac_seq_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [11:0] addr;
        logic [7:0] wdata;
    } lgac_ec_req_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [15:0] addr;
        logic [7:0] wdata;
    } lgac_io_req_type;

    typedef struct packed {
        logic write;
        logic cmd;
        logic [7:0] data;
    } lgac_kbd_wr_type;

    typedef struct packed {
        lgac_seq_type state;
        logic strobeN;
        logic cmd;
        logic [7:0] data;
        logic load;
        logic value;
        logic block;
    } lgac_seq_state_type;

    typedef struct packed {
        logic fwGate;
        logic hostLatch;
        logic [1:0] fastPort;
        logic gate;
        logic [7:0] ecRdata;
        logic [7:0] ioRdata;
        logic ioOeN;
    } lgac_main_state_type;

    localparam lgac_seq_state_type SEQ_RST_STATE = '{state: SEQ_IDLE, strobeN: 1'h1,
        cmd: 1'h0, data: 8'h00, load: 1'h0, value: 1'h0, block: 1'h0};

    localparam lgac_main_state_type MAIN_RST_STATE = '{fwGate: GATE_CTRL_RST,
        hostLatch: HOST_LATCH_RST, fastPort: FAST_PORT_RST, gate: 1'h1,
        ecRdata: 8'h00, ioRdata: 8'h00, ioOeN: 1'h1};

endpackage

// ### rtl/lgac_seq_fsm.sv
// Purpose: decodes the host command/data gate sequence
// Assumes: one keyboard write per cycle at most
// Notes: filtered bytes never reach the keyboard controller
`timescale 1ns/1ps
module lgac_seq_fsm (
    input wire logic core_clk,
    input wire logic rstn,
    input lgac_pkg::lgac_kbd_wr_type kbd,
    output logic internalWriteStrobeN,
    output logic kbdCmdOut,
    output logic [7:0] kbdDataOut,
    output logic latchLoad,
    output logic latchValue,
    output logic outputFullBlock
);

    lgac_pkg::lgac_seq_state_type q, d;

    function automatic logic isSilentCmd(input logic [7:0] b);
        isSilentCmd = (b == lgac_pkg::CMD_NOP) || (b == lgac_pkg::CMD_PULSE);
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.strobeN = 1'h1;
        d.load = 1'h0;
        d.cmd = kbd.cmd;
        d.data = kbd.data;
        if (kbd.write)
        begin
            if (kbd.cmd)
            begin
                if (kbd.data == lgac_pkg::CMD_GATE)
                begin
                    d.state = lgac_pkg::SEQ_CMD;
                end
                else if (isSilentCmd(kbd.data))
                begin
                    d.state = lgac_pkg::SEQ_IDLE;
                end
                else
                begin
                    d.strobeN = 1'h0;
                    d.state = lgac_pkg::SEQ_IDLE;
                end
            end
            else
            begin
                unique case (q.state)
                    lgac_pkg::SEQ_CMD:
                    begin
                        d.load = 1'h1;
                        d.value = kbd.data[lgac_pkg::DATA_GATE_BIT];
                        d.state = lgac_pkg::SEQ_DATA;
                    end
                    lgac_pkg::SEQ_DATA:
                    begin
                        d.strobeN = 1'h0;
                        d.state = lgac_pkg::SEQ_IDLE;
                    end
                    lgac_pkg::SEQ_IDLE:
                    begin
                        d.strobeN = 1'h0;
                    end
                endcase
            end
        end
        d.block = (d.state != lgac_pkg::SEQ_IDLE);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            q <= lgac_pkg::SEQ_RST_STATE;
        else
            q <= d;
    end

    assign internalWriteStrobeN = q.strobeN;
    assign kbdCmdOut = q.cmd;
    assign kbdDataOut = q.data;
    assign latchLoad = q.load;
    assign latchValue = q.value;
    assign outputFullBlock = q.block;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    data_copy_a: assert property (
        kbd.write && !kbd.cmd && q.state == lgac_pkg::SEQ_CMD
        |=> latchLoad && latchValue == $past(kbd.data[1]) && internalWriteStrobeN)
        else $error("gate data byte not copied");
    silent_cmd_a: assert property (
        kbd.write && kbd.cmd && (kbd.data == 8'hd1 || kbd.data == 8'hff || kbd.data == 8'hfe)
        |=> internalWriteStrobeN && !latchLoad)
        else $error("filtered command reached keyboard controller");
    repeat_cmd_a: assert property (
        kbd.write && kbd.cmd && kbd.data == 8'hd1 |=> q.state == lgac_pkg::SEQ_CMD)
        else $error("repeated gate command not accepted");
    bad_cmd_a: assert property (
        kbd.write && kbd.cmd && q.state == lgac_pkg::SEQ_CMD && !(kbd.data inside {8'hd1,
        8'hff, 8'hfe}) |=> !internalWriteStrobeN && !latchLoad && !outputFullBlock)
        else $error("invalid sequence not reported");
    extra_data_a: assert property (
        kbd.write && !kbd.cmd && q.state == lgac_pkg::SEQ_DATA
        |=> !internalWriteStrobeN && q.state == lgac_pkg::SEQ_IDLE)
        else $error("extra data byte not reported");
    hidden_seq_a: assert property (
        outputFullBlock |-> internalWriteStrobeN)
        else $error("strobe raised inside gate sequence");
    fwd_byte_a: assert property (
        kbd.write && q.state == lgac_pkg::SEQ_IDLE && !(kbd.cmd && kbd.data inside {8'hd1,
        8'hff, 8'hfe}) |=> !internalWriteStrobeN && kbdCmdOut == $past(kbd.cmd)
        && kbdDataOut == $past(kbd.data))
        else $error("idle byte not forwarded");

    turn_on_c: cover property (
        kbd.write && kbd.cmd && kbd.data == 8'hd1 ##1 kbd.write && !kbd.cmd ##1 latchLoad);
    invalid_c: cover property (
        q.state == lgac_pkg::SEQ_CMD ##0 kbd.write && kbd.cmd && kbd.data == 8'h20);

endmodule

// ### verif/lgac_gate_control_tb_top.sv
// Purpose: self-checking bench of the gate control block
// Assumes: host model drives the host side, bench drives the firmware bus
// Notes: gate checks wait a few cycles after each cause
`timescale 1ns/1ps
module lgac_gate_control_tb_top;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    lgac_pkg::lgac_ec_req_type ecReq = '0;
    logic firmwareAssistEnable = 1'b0;
    logic fastPortEnable = 1'b0;
    lgac_pkg::lgac_io_req_type ioReq;
    lgac_pkg::lgac_kbd_wr_type kbdWr;
    logic [7:0] ecRdata, ioRdata, kbdDataOut, rd, lastData;
    logic ioRdataOeN, internalWriteStrobeN, kbdCmdOut, outputFullBlock, lastCmd;
    logic fastPortReset, addressLine20Gate;
    int fails = 0;
    int checkCount = 0;
    int strobes = 0;
    int cycles = 0;
    int s0;

    always #5 core_clk = ~core_clk;

    lgac_gate_control lgac_gate_control_i (.core_clk(core_clk), .rstn(rstn), .ecReq(ecReq),
        .ecRdata(ecRdata), .ioReq(ioReq), .ioRdata(ioRdata), .ioRdataOeN(ioRdataOeN),
        .kbdWr(kbdWr), .internalWriteStrobeN(internalWriteStrobeN), .kbdCmdOut(kbdCmdOut),
        .kbdDataOut(kbdDataOut), .outputFullBlock(outputFullBlock),
        .firmwareAssistEnable(firmwareAssistEnable), .fastPortEnable(fastPortEnable),
        .fastPortReset(fastPortReset), .addressLine20Gate(addressLine20Gate));

    lgac_host_model lgac_host_model_i (.core_clk(core_clk), .ioRdata(ioRdata),
        .ioRdataOeN(ioRdataOeN), .ioReq(ioReq), .kbdWr(kbdWr));

    // ----------------------------------------------------------------
    // monitors and helpers
    // ----------------------------------------------------------------
    always @(posedge core_clk)
    begin
        cycles++;
        if (internalWriteStrobeN === 1'b0)
        begin
            strobes++;
            lastData = kbdDataOut;
            lastCmd = kbdCmdOut;
        end
        if (cycles == 5000)
        begin
            fails++;
            completeRun();
        end
    end

    task automatic completeRun();
        $display("checks=%0d fails=%0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp);
        checkByte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic ec(input logic wr, input logic [11:0] addr, input logic [7:0] wd);
        @(posedge core_clk);
        ecReq <= '{write: wr, read: !wr, addr: addr, wdata: wd};
        @(posedge core_clk);
        ecReq <= '0;
        #1;
        rd = ecRdata;
    endtask

    task automatic io(input logic wr, input logic [7:0] wd);
        lgac_host_model_i.ioCycle(wr, lgac_pkg::FAST_PORT_IO_ADDR, wd, rd);
    endtask

    task automatic k(input logic cmd, input logic [7:0] data);
        lgac_host_model_i.kbdSend(cmd, data);
    endtask

    task automatic gateIs(input logic exp);
        repeat (3) @(posedge core_clk);
        #1;
        checkBit(addressLine20Gate, exp);
    endtask

    task automatic setIn(input logic assist, input logic fastEn);
        @(posedge core_clk);
        firmwareAssistEnable <= assist;
        fastPortEnable <= fastEn;
    endtask

    task automatic doReset();
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic testReset();
        checkBit(addressLine20Gate, 1'b1);
        checkBit(outputFullBlock, 1'b0);
        checkBit(ioRdataOeN, 1'b1);
        ec(1'b0, lgac_pkg::GATE_CTRL_OFF, 8'h00);
        checkByte(rd, 8'h01);
        ec(1'b0, lgac_pkg::LATCH_SET_OFF, 8'h00);
        checkByte(rd, 8'h00);
    endtask

    task automatic testStrobes();
        ec(1'b1, lgac_pkg::LATCH_CLR_OFF, 8'hff);
        gateIs(1'b0);
        ec(1'b0, lgac_pkg::GATE_CTRL_OFF, 8'h00);
        checkByte(rd, 8'h00);
        ec(1'b1, lgac_pkg::LATCH_SET_OFF, 8'h00);
        gateIs(1'b1);
        ec(1'b0, lgac_pkg::GATE_CTRL_OFF, 8'h00);
        checkByte(rd, 8'h01);
    endtask

    task automatic testSequence();
        ec(1'b1, lgac_pkg::LATCH_CLR_OFF, 8'h00);
        s0 = strobes;
        k(1'b1, 8'hd1);
        gateIs(1'b0);
        checkBit(outputFullBlock, 1'b1);
        k(1'b0, 8'hdf);
        gateIs(1'b1);
        k(1'b1, 8'hff);
        gateIs(1'b1);
        checkBit(outputFullBlock, 1'b0);
        k(1'b1, 8'hd1);
        k(1'b0, 8'hdd);
        gateIs(1'b0);
        k(1'b1, 8'hd1);
        k(1'b1, 8'hd1);
        k(1'b0, 8'h02);
        gateIs(1'b1);
        k(1'b1, 8'hd1);
        k(1'b0, 8'hfd);
        gateIs(1'b0);
        k(1'b1, 8'hff);
        k(1'b1, 8'hfe);
        gateIs(1'b0);
        checkByte(8'(strobes - s0), 8'h00);
    endtask

    task automatic testInvalid();
        s0 = strobes;
        k(1'b1, 8'hd1);
        k(1'b1, 8'haa);
        gateIs(1'b0);
        checkByte(8'(strobes - s0), 8'h01);
        checkBit(outputFullBlock, 1'b0);
        k(1'b1, 8'hd1);
        k(1'b0, 8'hdf);
        k(1'b0, 8'hdd);
        gateIs(1'b1);
        checkByte(8'(strobes - s0), 8'h02);
        checkBit(outputFullBlock, 1'b0);
        k(1'b1, 8'h60);
        gateIs(1'b1);
        checkByte(8'(strobes - s0), 8'h03);
        checkByte(lastData, 8'h60);
        checkBit(lastCmd, 1'b1);
        k(1'b0, 8'h55);
        gateIs(1'b1);
        checkByte(8'(strobes - s0), 8'h04);
        checkByte(lastData, 8'h55);
        checkBit(lastCmd, 1'b0);
    endtask

    task automatic testAssist();
        ec(1'b1, lgac_pkg::LATCH_SET_OFF, 8'h00);
        setIn(1'b1, 1'b0);
        gateIs(1'b0);
        ec(1'b0, lgac_pkg::GATE_CTRL_OFF, 8'h00);
        checkByte(rd, 8'h00);
        ec(1'b1, lgac_pkg::GATE_CTRL_OFF, 8'hff);
        gateIs(1'b1);
        ec(1'b0, lgac_pkg::GATE_CTRL_OFF, 8'h00);
        checkByte(rd, 8'h01);
        ec(1'b1, lgac_pkg::LATCH_CLR_OFF, 8'h00);
        gateIs(1'b1);
        ec(1'b1, lgac_pkg::GATE_CTRL_OFF, 8'hfe);
        gateIs(1'b0);
        setIn(1'b0, 1'b0);
        gateIs(1'b0);
        ec(1'b1, lgac_pkg::LATCH_SET_OFF, 8'h00);
        gateIs(1'b1);
        ec(1'b0, lgac_pkg::GATE_CTRL_OFF, 8'h00);
        checkByte(rd, 8'h01);
        ec(1'b1, lgac_pkg::LATCH_CLR_OFF, 8'h00);
    endtask

    task automatic testFastPort();
        setIn(1'b0, 1'b1);
        io(1'b1, 8'h02);
        gateIs(1'b1);
        io(1'b0, 8'h00);
        checkByte(rd, 8'h02);
        @(posedge core_clk);
        #1;
        checkBit(ioRdataOeN, 1'b1);
        checkBit(fastPortReset, 1'b0);
        io(1'b1, 8'h00);
        gateIs(1'b0);
        io(1'b1, 8'h01);
        gateIs(1'b0);
        checkBit(fastPortReset, 1'b1);
        ec(1'b0, lgac_pkg::FAST_PORT_EC_OFF, 8'h00);
        checkByte(rd, 8'h01);
        ec(1'b1, lgac_pkg::FAST_PORT_EC_OFF, 8'h02);
        gateIs(1'b1);
        checkBit(fastPortReset, 1'b0);
        io(1'b1, 8'h00);
        ec(1'b1, lgac_pkg::LATCH_SET_OFF, 8'h00);
        gateIs(1'b1);
        ec(1'b1, lgac_pkg::LATCH_CLR_OFF, 8'h00);
        gateIs(1'b0);
        setIn(1'b0, 1'b0);
        io(1'b1, 8'h02);
        gateIs(1'b0);
        io(1'b0, 8'h00);
        checkByte(rd, 8'hff);
    endtask

    task automatic testMidReset();
        k(1'b1, 8'hd1);
        doReset();
        checkBit(addressLine20Gate, 1'b1);
        checkBit(outputFullBlock, 1'b0);
        ec(1'b0, lgac_pkg::GATE_CTRL_OFF, 8'h00);
        checkByte(rd, 8'h01);
    endtask

    initial
    begin
        doReset();
        testReset();
        testStrobes();
        testSequence();
        testInvalid();
        testAssist();
        testFastPort();
        testMidReset();
        completeRun();
    end
endmodule

// ### verif/lgac_host_model.sv
// Purpose: host side model issuing fast port I/O cycles and keyboard port writes
// Assumes: requests are one-cycle pulses taken at the rising edge
// Notes: the data bus is pulled up, so an undriven read returns ff
`timescale 1ns/1ps
module lgac_host_model (
    input wire logic core_clk,
    input wire logic [7:0] ioRdata,
    input wire logic ioRdataOeN,
    output lgac_pkg::lgac_io_req_type ioReq,
    output lgac_pkg::lgac_kbd_wr_type kbdWr
);
    logic [7:0] busData;

    // pulled-up bus when the device does not drive
    assign busData = (ioRdataOeN === 1'b0) ? ioRdata : 8'hff;

    initial
    begin
        ioReq = '0;
        kbdWr = '0;
    end

    task automatic ioCycle(input logic wr, input logic [15:0] addr, input logic [7:0] wd,
                           output logic [7:0] rd);
        @(posedge core_clk);
        ioReq <= '{write: wr, read: !wr, addr: addr, wdata: wd};
        @(posedge core_clk);
        ioReq <= '0;
        #1;
        rd = busData;
    endtask

    task automatic kbdSend(input logic cmd, input logic [7:0] data);
        @(posedge core_clk);
        kbdWr <= '{write: 1'h1, cmd: cmd, data: data};
        @(posedge core_clk);
        kbdWr <= '0;
    endtask
endmodule
